// file: src/osc_params.svh
// constants for the oversampling conversion control block
// assumes a 100 MHz system clock
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH
// ==========================================
// timing
`define OSC_CLK_PERIOD_NS 10
`define OSC_CONV_TIME_NS 4000
`define OSC_ACQ_TIME_NS 1000
`define OSC_CONV_CYCLES ((`OSC_CONV_TIME_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS)
`define OSC_ACQ_CYCLES ((`OSC_ACQ_TIME_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS)
// ==========================================
// data shape
`define OSC_CHANNELS 8
`define OSC_RES_BITS 14
`define OSC_MAX_RATIO_LOG 6
`define OSC_RATIO_ILLEGAL 3'h7
`endif

// file: src/osc_pkg.sv
// types for the oversampling conversion control block
// assumes nothing outside itself
package osc_pkg;
   typedef enum logic [1:0] {OSC_IDLE, OSC_CONVERT, OSC_ACQUIRE} osc_state_t;
endpackage

// file: src/osc_accum.sv
// per-channel sample accumulator and decimator
// assumes samples arrive one strobe per conversion, all channels at once
`timescale 1ns/1ps
`include "osc_params.svh"
module osc_accum
   import osc_pkg::*;
#(
   parameter int CHANNELS = `OSC_CHANNELS,
   parameter int RES = `OSC_RES_BITS,
   parameter int LOGMAX = `OSC_MAX_RATIO_LOG
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // control
   input wire logic clear_i,
   input wire logic add_i,
   input wire logic store_i,
   input wire logic [2:0] shift_i,
   // data
   input wire logic [CHANNELS*RES-1:0] sample_i,
   output logic [CHANNELS*RES-1:0] result_o
);
   localparam int AW = RES + LOGMAX;
   logic [AW-1:0] acc [CHANNELS];
   initial begin
      if (CHANNELS < 1 || RES < 2 || LOGMAX != 6) $error("osc_accum bad params");
   end
   // ==========================================
   // accumulate, then decimate back to RES bits; signed so the shift keeps sign
   genvar g;
   for (g = 0; g < CHANNELS; g++) begin : g_ch
      wire logic [AW-1:0] ext = {{LOGMAX{sample_i[g*RES+RES-1]}}, sample_i[g*RES +: RES]};
      wire logic [AW-1:0] sum = (clear_i ? '0 : acc[g]) + ext;
      wire logic signed [AW-1:0] avg = $signed(sum) >>> shift_i;
      always_ff @(posedge clock_i or negedge rstn_i) begin
         if (!rstn_i) begin
            acc[g] <= '0;
         end else if (add_i) begin
            acc[g] <= sum;
         end
      end
      always_ff @(posedge clock_i or negedge rstn_i) begin
         if (!rstn_i) begin
            result_o[g*RES +: RES] <= '0;
         end else if (store_i) begin
            result_o[g*RES +: RES] <= avg[RES-1:0];
         end
      end
   end
endmodule

// file: src/osc_ctrl.sv
// oversampling conversion control: convert-start, busy, ratio latch, averaging
// assumes inputs synchronous to clock_i; samples supplied by the analog front end
// Functional notes
// - Results may be read while busy is high without disturbing conversion.
// - Ratio select 000..110 gives 1,2,4,8,16,32,64; 111 is illegal.
// - Ratio select is captured when busy falls; governs the next cycle.
// - Busy lasts N conversions plus N-1 acquisitions; one conversion at N=1.
// - Each channel always delivers a 14-bit decimated result.
// - Every cycle converts all eight channels together.
// - Busy rises at convert-start, falls after conversions; one conversion is 4 us.
// - Staggered starts hold channel groups separately; busy starts at later edge.
`timescale 1ns/1ps
`include "osc_params.svh"
module osc_ctrl
   import osc_pkg::*;
#(
   parameter int CHANNELS = `OSC_CHANNELS,
   parameter int RES = `OSC_RES_BITS,
   parameter int CONV_CYC = `OSC_CONV_CYCLES,
   parameter int ACQ_CYC = `OSC_ACQ_CYCLES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // convert start and ratio select
   input wire logic convert_start_group_low_i,
   input wire logic convert_start_group_high_i,
   input wire logic ratio_sel_msb_i,
   input wire logic ratio_sel_mid_i,
   input wire logic ratio_sel_lsb_i,
   // analog front end
   input wire logic [CHANNELS*RES-1:0] sample_i,
   output logic hold_group_low_o,
   output logic hold_group_high_o,
   output logic sample_strobe_o,
   // status and results
   output logic busy_o,
   output logic [2:0] ratio_log_o,
   output logic [CHANNELS*RES-1:0] result_o
);
   localparam int CW = 16;
   initial begin
      if (CONV_CYC < 1 || ACQ_CYC < 1 || CONV_CYC >= 2**CW || ACQ_CYC >= 2**CW)
         $error("osc_ctrl bad timing params");
   end
   // ==========================================
   // reset release
   logic rst_q1, rst_n;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end
   // ==========================================
   // edge detection on convert-start inputs
   logic cs_lo_q, cs_hi_q, armed_lo, armed_hi;
   wire logic rise_lo = convert_start_group_low_i & ~cs_lo_q;
   wire logic rise_hi = convert_start_group_high_i & ~cs_hi_q;
   osc_state_t state, next_state;
   wire logic idle = (state == OSC_IDLE);
   // start once both groups have seen an edge; covers tied and staggered starts
   wire logic got_lo = armed_lo | rise_lo;
   wire logic got_hi = armed_hi | rise_hi;
   wire logic start = idle & got_lo & got_hi;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         cs_lo_q <= 1'b0;
         cs_hi_q <= 1'b0;
      end else begin
         cs_lo_q <= convert_start_group_low_i;
         cs_hi_q <= convert_start_group_high_i;
      end
   end
   // per-group hold arm, cleared when conversion starts
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         armed_lo <= 1'b0;
         armed_hi <= 1'b0;
      end else begin
         armed_lo <= idle & got_lo & ~start;
         armed_hi <= idle & got_hi & ~start;
      end
   end
   // track-and-hold: group held from its own edge until busy ends
   assign hold_group_low_o = ~idle | armed_lo;
   assign hold_group_high_o = ~idle | armed_hi;
   // ==========================================
   // ratio decode and latch
   wire logic [2:0] sel = {ratio_sel_msb_i, ratio_sel_mid_i, ratio_sel_lsb_i};
   // illegal code treated as ratio one; the host must never apply it
   wire logic [2:0] sel_log = (sel == `OSC_RATIO_ILLEGAL) ? 3'h0 : sel;
   logic [2:0] ratio_log;
   logic [6:0] samples_left;
   logic [CW-1:0] cnt;
   wire logic cnt_done = (cnt == '0);
   wire logic last_conv = (state == OSC_CONVERT) & cnt_done & (samples_left == 7'h01);
   wire logic busy_fall = last_conv;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ratio_log <= 3'h0;
      end else if (busy_fall) begin
         ratio_log <= sel_log;
      end
   end
   assign ratio_log_o = ratio_log;
   // ==========================================
   // sequencer: conversion, acquisition, repeat N times
   always_comb begin
      next_state = state;
      unique case (state)
         OSC_IDLE: if (start) next_state = OSC_CONVERT;
         OSC_CONVERT: if (cnt_done) next_state = last_conv ? OSC_IDLE : OSC_ACQUIRE;
         OSC_ACQUIRE: if (cnt_done) next_state = OSC_CONVERT;
      endcase
   end
   wire logic [CW-1:0] conv_load = CW'(CONV_CYC - 1);
   wire logic [CW-1:0] acq_load = CW'(ACQ_CYC - 1);
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= OSC_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // cycle counter: busy = N*conv + (N-1)*acq
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (start || (state == OSC_ACQUIRE && cnt_done)) begin
         cnt <= conv_load;
      end else if (state == OSC_CONVERT && cnt_done && !last_conv) begin
         cnt <= acq_load;
      end else if (!cnt_done) begin
         cnt <= cnt - 1'b1;
      end
   end
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         samples_left <= 7'h00;
      end else if (start) begin
         samples_left <= 7'h01 << ratio_log;
      end else if (state == OSC_CONVERT && cnt_done) begin
         samples_left <= samples_left - 7'h01;
      end
   end
   assign busy_o = ~idle;
   // ==========================================
   // averaging: all channels take one sample per conversion
   wire logic conv_end = (state == OSC_CONVERT) & cnt_done;
   logic first_sample;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         first_sample <= 1'b0;
      end else if (start) begin
         first_sample <= 1'b1;
      end else if (conv_end) begin
         first_sample <= 1'b0;
      end
   end
   assign sample_strobe_o = conv_end;
   // results register is only written at busy end, so reads never disturb it
   osc_accum #(
      .CHANNELS(CHANNELS),
      .RES(RES),
      .LOGMAX(`OSC_MAX_RATIO_LOG)
   ) u_accum (
      .clock_i(clock_i),
      .rstn_i(rst_n),
      .clear_i(first_sample),
      .add_i(conv_end),
      .store_i(last_conv),
      .shift_i(ratio_log),
      .sample_i(sample_i),
      .result_o(result_o)
   );
   // ==========================================
   // assertions
   logic [CW+7:0] busy_len;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= '0;
      end else begin
         busy_len <= busy_o ? busy_len + 1'b1 : '0;
      end
   end
   // the latch moves at the last edge of busy, so the ratio that ran is the past one
   a_busy_single_len: assert property (@(posedge clock_i) disable iff (!rst_n)
      ($fell(busy_o) && $past(ratio_log) == 3'h0) |-> ($past(busy_len) == CONV_CYC - 1))
      else $error("busy length wrong at ratio one");
   // busy span in cycles for a ratio of two to the power lg
   function automatic int busy_cycles(input logic [2:0] lg);
      busy_cycles = (CONV_CYC << lg) + (ACQ_CYC << lg) - ACQ_CYC;
   endfunction
   a_busy_ratio_len: assert property (@(posedge clock_i) disable iff (!rst_n)
      $fell(busy_o) |-> ($past(busy_len) == busy_cycles($past(ratio_log)) - 1))
      else $error("busy length wrong for ratio");
   a_busy_rise_start: assert property (@(posedge clock_i) disable iff (!rst_n)
      start |=> busy_o)
      else $error("busy did not rise on start");
   a_ratio_latch_fall: assert property (@(posedge clock_i) disable iff (!rst_n)
      busy_fall |=> (ratio_log == $past(sel_log)))
      else $error("ratio not latched at busy fall");
   a_ratio_stable_busy: assert property (@(posedge clock_i) disable iff (!rst_n)
      (busy_o && !busy_fall) |=> $stable(ratio_log))
      else $error("ratio changed during busy");
   a_ratio_decode: assert property (@(posedge clock_i) disable iff (!rst_n)
      (sel != `OSC_RATIO_ILLEGAL) |-> (sel_log == sel))
      else $error("ratio decode wrong");
   a_result_store_end: assert property (@(posedge clock_i) disable iff (!rst_n)
      (busy_o && !$past(busy_fall)) |-> $stable(result_o))
      else $error("result changed mid conversion");
   a_strobe_in_busy: assert property (@(posedge clock_i) disable iff (!rst_n)
      sample_strobe_o |-> busy_o)
      else $error("sample strobe outside busy");
   a_stagger_later: assert property (@(posedge clock_i) disable iff (!rst_n)
      (idle && armed_lo && !got_hi) |=> !busy_o)
      else $error("busy began before later start");
   a_acq_after_conv: assert property (@(posedge clock_i) disable iff (!rst_n)
      (conv_end && !last_conv) |=> (state == OSC_ACQUIRE))
      else $error("no acquisition between samples");
endmodule

// file: verif/osc_front_model.sv
// analog front end stand-in: every channel steps once per sample strobe
// assumes the strobe is a one-cycle pulse synchronous to clock_i
`timescale 1ns/1ps
module osc_front_model #(
   parameter int CHANNELS = 8,
   parameter int RES = 14
) (
   // clock and strobe
   input wire logic clock_i,
   input wire logic sample_strobe_i,
   // samples
   output logic [CHANNELS*RES-1:0] sample_o
);
   int count = 0;
   // advance after each capture so an average sees distinct samples
   always @(posedge clock_i) begin
      if (sample_strobe_i === 1'b1) begin
         count <= count + 1;
      end
   end
   // all channels presented together, offset per channel
   always_comb begin
      for (int k = 0; k < CHANNELS; k++) begin
         sample_o[k*RES +: RES] = RES'(count + k * 256);
      end
   end
endmodule

// file: verif/oversampling_conversion_control_tb.sv
// self-checking bench for the conversion control block
// assumes short conversion and acquisition counts of 4 and 2 cycles
`timescale 1ns/1ps
module oversampling_conversion_control_tb;
   import osc_pkg::*;
   localparam int CC = 4;
   localparam int AC = 2;
   logic clock_i, resetn_i, cs_lo, cs_hi, hold_lo, hold_hi, strobe, busy_o;
   logic [2:0] sel, ratio_log_o;
   logic [111:0] sample, result_o;
   int failures = 0;
   int n_checks = 0;
   int nstr = 0;
   // ==========================================
   // design and front end
   osc_ctrl #(.CONV_CYC(CC), .ACQ_CYC(AC)) osc_ctrl_inst (.clock_i(clock_i),
      .resetn_i(resetn_i), .convert_start_group_low_i(cs_lo),
      .convert_start_group_high_i(cs_hi), .ratio_sel_msb_i(sel[2]),
      .ratio_sel_mid_i(sel[1]), .ratio_sel_lsb_i(sel[0]), .sample_i(sample),
      .hold_group_low_o(hold_lo), .hold_group_high_o(hold_hi),
      .sample_strobe_o(strobe), .busy_o(busy_o), .ratio_log_o(ratio_log_o),
      .result_o(result_o));
   osc_front_model osc_front_model_inst (.clock_i(clock_i), .sample_strobe_i(strobe),
      .sample_o(sample));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // ==========================================
   // compares and closing
   task automatic chk_n(input int got, input int exp, input string m);
      n_checks++;
      if (got != exp) begin
         failures++;
         $display("wrong value at %0t: %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask
   task automatic chk_v(input logic [111:0] got, input logic [111:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // one conversion cycle; stag > 0 delays the high group by stag + 1 cycles
   task automatic run(input int stag, input int n, input logic [2:0] lg);
      int cyc, str;
      logic [111:0] e, prev;
      cyc = 0;
      str = 0;
      prev = result_o;
      cs_lo <= 1'b1;
      if (stag > 0) begin
         repeat (stag) @(posedge clock_i);
         #1 chk_v(112'({busy_o, hold_lo, hold_hi}), 112'h2, "stagger");
         @(posedge clock_i);
      end
      cs_hi <= 1'b1;
      for (int i = 0; i < 1000; i++) begin
         @(posedge clock_i);
         // a second start while busy must be ignored
         if (cyc == 1 || cyc == 3) begin
            cs_lo <= 1'b0;
            cs_hi <= 1'b0;
         end else if (cyc == 2) begin
            cs_lo <= 1'b1;
            cs_hi <= 1'b1;
         end
         #1;
         if (strobe === 1'b1) str++;
         if (busy_o === 1'b1) begin
            // start is seen one edge after the request, so busy shows at the first edge
            if (cyc == 0) chk_n(i, 0, "busy rise");
            if (cyc == 1) chk_v(112'({hold_lo, hold_hi}), 112'h3, "hold");
            if (cyc == 2) chk_v(result_o, prev, "read in busy");
            cyc++;
         end else if (cyc > 0) break;
      end
      chk_n(cyc, n * CC + (n - 1) * AC, "busy length");
      chk_n(str, n, "samples");
      chk_v(112'(ratio_log_o), 112'(lg), "ratio");
      for (int k = 0; k < 8; k++) e[k*14 +: 14] = 14'(nstr + (n > 1 ? n / 2 - 1 : 0) + k * 256);
      chk_v(result_o, e, "result");
      nstr += n;
      repeat (AC + 2) @(posedge clock_i);
      #1 chk_v(112'(busy_o), 112'h0, "idle");
      // next stimulus goes out on a rising edge
      @(posedge clock_i);
   endtask
   // ==========================================
   // test sequence
   initial begin
      resetn_i = 1'b0;
      cs_lo = 1'b0;
      cs_hi = 1'b0;
      sel = 3'h0;
      repeat (10) @(posedge clock_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk_v(112'({busy_o, ratio_log_o}), 112'h0, "reset");
      run(0, 1, 3'h0);
      $display("test 0 done");
      // each code takes effect one cycle after it is latched
      for (int c = 1; c <= 8; c++) begin
         sel <= 3'(c % 8);
         run(0, (c == 1 || c == 8) ? 1 : 1 << (c - 1), (c % 8 == 7) ? 3'h0 : 3'(c % 8));
         $display("test %0d done", c);
      end
      run(3, 1, 3'h0);
      $display("test stagger done");
      wrap_up();
   end
   // hang guard, far beyond the longest sequence
   initial begin
      #500000;
      failures++;
      wrap_up();
   end
endmodule
